/* File: hw/galu_pkg.sv */
// Package with encodings, operation codes and carrier types of the ALU.
package galu_pkg;

  // ------------------------------------------------------------
  // Instruction field positions and encodings.
  // ------------------------------------------------------------
  localparam int OPCODE_LSB = 0;
  localparam int FUNCT3_LSB = 12;
  localparam int RS2F_LSB = 20;
  localparam int SHAMT_LSB = 25;
  localparam int FUNCT7_LSB = 25;
  localparam int F2_LSB = 30;
  localparam logic [6:0] OPC_REG = 7'h2B;
  localparam logic [6:0] OPC_NORM = 7'h5B;
  localparam logic [2:0] F3_REG = 3'h3;
  localparam logic [2:0] F3_NADD = 3'h2;
  localparam logic [2:0] F3_NSUB = 3'h3;

  // ------------------------------------------------------------
  // Seven-bit selectors of the register-form operations, and the four-bit accumulate prefix.
  // ------------------------------------------------------------
  localparam logic [6:0] F7_ABS = 7'h28;
  localparam logic [6:0] F7_SLE = 7'h29;
  localparam logic [6:0] F7_SLEU = 7'h2A;
  localparam logic [6:0] F7_MIN = 7'h2B;
  localparam logic [6:0] F7_MINU = 7'h2C;
  localparam logic [6:0] F7_MAX = 7'h2D;
  localparam logic [6:0] F7_MAXU = 7'h2E;
  localparam logic [6:0] F7_EXTHS = 7'h30;
  localparam logic [6:0] F7_EXTHZ = 7'h31;
  localparam logic [6:0] F7_EXTBS = 7'h32;
  localparam logic [6:0] F7_EXTBZ = 7'h33;
  localparam logic [6:0] F7_CLIP = 7'h38;
  localparam logic [6:0] F7_CLIPU = 7'h39;
  localparam logic [6:0] F7_CLIPR = 7'h3A;
  localparam logic [6:0] F7_CLIPUR = 7'h3B;
  localparam logic [3:0] F7_ACC_HI = 4'h8;

  // ------------------------------------------------------------
  // Reset values and latency.
  // ------------------------------------------------------------
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam int LATENCY_CYCLES = 1;

  // ------------------------------------------------------------
  // Operation classes and carriers.
  // ------------------------------------------------------------
  typedef enum {
    GALU_ILLEGAL, GALU_ABS, GALU_SLE, GALU_SLEU, GALU_MIN, GALU_MINU,
    GALU_MAX, GALU_MAXU, GALU_EXTHS, GALU_EXTHZ, GALU_EXTBS, GALU_EXTBZ,
    GALU_CLIP, GALU_CLIPU, GALU_CLIPR, GALU_CLIPUR, GALU_NORM
  } galu_op_t;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [31:0] dest_old;
  } galu_req_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic [31:0] result;
  } galu_rsp_t;

  typedef struct packed {
    logic sub;
    logic unsign;
    logic round;
    logic [4:0] shift;
    logic [31:0] opa;
    logic [31:0] opb;
  } galu_norm_t;

endpackage

/* File: hw/galu_norm.sv */
// Normalizing add or subtract with optional rounding and right shift.
module galu_norm #(
  parameter int WIDTH = 32
) (
  input wire galu_pkg::galu_norm_t cmd,
  output logic [31:0] result
);

  // ------------------------------------------------------------
  // Elaboration check.
  // ------------------------------------------------------------
  if (WIDTH != 32)
  begin : g_chk
    $error("Normalizer supports only a 32-bit datapath.");
  end

  // ------------------------------------------------------------
  // Datapath.
  // ------------------------------------------------------------
  logic [31:0] sum;
  logic [31:0] round_term;
  logic [31:0] total;
  logic [4:0] shift_less;

  assign shift_less = cmd.shift - 5'h01;
  assign sum = cmd.sub ? cmd.opa - cmd.opb : cmd.opa + cmd.opb;
  assign round_term = (cmd.round && cmd.shift != 5'h00) ?
    (32'h0000_0001 << shift_less) : 32'h0000_0000;
  assign total = sum + round_term;
  assign result = cmd.unsign ? (total >> cmd.shift)
    : 32'($signed(total) >>> cmd.shift);

endmodule

/* File: hw/galu_top.sv */
// General ALU datapath for custom integer instructions, one-cycle latency.
// Behaviour
// - Absolute value negates a negative first source, else passes it.
// - Set-less-equal writes 1 when src1 <= src2, signed or unsigned.
// - Minimum returns src1 when below src2, else src2.
// - Maximum returns src2 when src1 below it, else src1.
// - Unsigned sle, min and max compare both sources as unsigned magnitudes.
// - Extensions take low 16 or 8 bits, sign or zero extended.
// - Signed immediate clip saturates to -2^(width-1) and 2^(width-1)-1.
// - Width zero gives signed clip bounds -1 and 0.
// - Unsigned immediate clip floors at 0, caps at 2^(width-1)-1.
// - Signed register clip bounds are -(src2+1) and src2.
// - Unsigned register clip bounds are 0 and src2.
// - Signed immediate normalize adds or subtracts, shifts arithmetic.
// - Unsigned immediate normalize adds or subtracts, then shifts logical.
// - Rounding forms add 2^(shift-1) before shifting.
// - Zero shift gives zero rounding term.
// - Signed accumulate form uses dest and src1, arithmetic shift.
// - Unsigned accumulate form uses dest and src1, logical shift.
// - Accumulate rounding uses src2 low five bits, zero when zero.
// - Register forms decode opcode 0x2B, funct3 3, funct7 per op.
// - Immediate normalize decodes opcode 0x5B, funct3 2 add, 3 sub.
module galu_top #(
  parameter int WIDTH = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire galu_pkg::galu_req_t req,
  output galu_pkg::galu_rsp_t rsp
);

  // ------------------------------------------------------------
  // Elaboration check.
  // ------------------------------------------------------------
  if (WIDTH != 32)
  begin : g_chk
    $error("ALU supports only a 32-bit datapath.");
  end

  // ------------------------------------------------------------
  // Helper functions.
  // ------------------------------------------------------------
  function automatic logic less_than(input logic [31:0] a,
                                     input logic [31:0] b,
                                     input logic uns);
    less_than = uns ? (a < b) : ($signed(a) < $signed(b));
  endfunction

  function automatic logic [31:0] clamp(input logic [31:0] x,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi,
                                        input logic uns);
    if (!less_than(lo, x, uns))
    begin
      clamp = lo;
    end
    else if (!less_than(x, hi, uns))
    begin
      clamp = hi;
    end
    else
    begin
      clamp = x;
    end
  endfunction

  // ------------------------------------------------------------
  // Instruction fields.
  // ------------------------------------------------------------
  wire [6:0] opcode = req.instr[galu_pkg::OPCODE_LSB +: 7];
  wire [2:0] funct3 = req.instr[galu_pkg::FUNCT3_LSB +: 3];
  wire [6:0] funct7 = req.instr[galu_pkg::FUNCT7_LSB +: 7];
  wire [1:0] f2 = req.instr[galu_pkg::F2_LSB +: 2];
  wire [4:0] shift_imm = req.instr[galu_pkg::SHAMT_LSB +: 5];
  wire [4:0] clip_width_imm = req.instr[galu_pkg::RS2F_LSB +: 5];
  wire [31:0] src1 = req.src1;
  wire [31:0] src2 = req.src2;

  // ------------------------------------------------------------
  // Decode.
  // ------------------------------------------------------------
  wire is_reg = opcode == galu_pkg::OPC_REG && funct3 == galu_pkg::F3_REG;
  wire is_imm_norm = opcode == galu_pkg::OPC_NORM &&
    (funct3 == galu_pkg::F3_NADD || funct3 == galu_pkg::F3_NSUB);
  wire is_acc = is_reg && funct7[6:3] == galu_pkg::F7_ACC_HI;
  galu_pkg::galu_op_t op;

  always_comb
  begin
    op = galu_pkg::GALU_ILLEGAL;
    if (is_imm_norm || is_acc)
    begin
      op = galu_pkg::GALU_NORM;
    end
    else if (is_reg)
    begin
      case (funct7)
        galu_pkg::F7_ABS:
        begin
          op = galu_pkg::GALU_ABS;
        end
        galu_pkg::F7_SLE:
        begin
          op = galu_pkg::GALU_SLE;
        end
        galu_pkg::F7_SLEU:
        begin
          op = galu_pkg::GALU_SLEU;
        end
        galu_pkg::F7_MIN:
        begin
          op = galu_pkg::GALU_MIN;
        end
        galu_pkg::F7_MINU:
        begin
          op = galu_pkg::GALU_MINU;
        end
        galu_pkg::F7_MAX:
        begin
          op = galu_pkg::GALU_MAX;
        end
        galu_pkg::F7_MAXU:
        begin
          op = galu_pkg::GALU_MAXU;
        end
        galu_pkg::F7_EXTHS:
        begin
          op = galu_pkg::GALU_EXTHS;
        end
        galu_pkg::F7_EXTHZ:
        begin
          op = galu_pkg::GALU_EXTHZ;
        end
        galu_pkg::F7_EXTBS:
        begin
          op = galu_pkg::GALU_EXTBS;
        end
        galu_pkg::F7_EXTBZ:
        begin
          op = galu_pkg::GALU_EXTBZ;
        end
        galu_pkg::F7_CLIP:
        begin
          op = galu_pkg::GALU_CLIP;
        end
        galu_pkg::F7_CLIPU:
        begin
          op = galu_pkg::GALU_CLIPU;
        end
        galu_pkg::F7_CLIPR:
        begin
          op = galu_pkg::GALU_CLIPR;
        end
        galu_pkg::F7_CLIPUR:
        begin
          op = galu_pkg::GALU_CLIPUR;
        end
        default:
        begin
          op = galu_pkg::GALU_ILLEGAL;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Comparisons and clip bounds.
  // ------------------------------------------------------------
  wire [31:0] neg_src1 = 32'h0000_0000 - src1;
  wire [31:0] abs_src1 = src1[31] ? neg_src1 : src1;
  wire [31:0] ext_hs = {{16{src1[15]}}, src1[15:0]};
  wire [31:0] ext_hz = {16'h0000, src1[15:0]};
  wire [31:0] ext_bs = {{24{src1[7]}}, src1[7:0]};
  wire [31:0] ext_bz = {24'h00_0000, src1[7:0]};
  wire lt_s = less_than(src1, src2, 1'b0);
  wire lt_u = less_than(src1, src2, 1'b1);
  wire le_s = !less_than(src2, src1, 1'h0);
  wire le_u = !less_than(src2, src1, 1'h1);
  wire [4:0] width_less = clip_width_imm - 5'h01;
  wire [31:0] pow_imm = (clip_width_imm == 5'h00) ? 32'h0000_0000
    : (32'h0000_0001 << width_less);
  wire [31:0] imm_hi = (clip_width_imm == 5'h00) ? 32'h0000_0000
    : pow_imm - 32'h0000_0001;
  wire [31:0] imm_lo = (clip_width_imm == 5'h00) ? 32'hFFFF_FFFF
    : 32'h0000_0000 - pow_imm;
  wire [31:0] reg_lo = 32'h0000_0000 - (src2 + 32'h0000_0001);

  // Both register clips rely on src2 staying within 0 to 0x7FFFFFFF.
  wire [31:0] clip_s_imm = clamp(src1, imm_lo, imm_hi, 1'b0);
  // Lower bound 0 is compared signed so negative sources floor to zero.
  wire [31:0] clip_u_imm = clamp(src1, 32'h0000_0000, imm_hi, 1'b0);
  wire [31:0] clip_s_reg =
    clamp(src1, reg_lo, src2, 1'b0);
  wire [31:0] clip_u_reg =
    clamp(src1, 32'h0000_0000, src2, 1'b0);

  // ------------------------------------------------------------
  // Normalizing add and subtract.
  // ------------------------------------------------------------
  galu_pkg::galu_norm_t norm_cmd;
  logic [31:0] norm_result;

  always_comb
  begin
    norm_cmd.sub = 1'b0;
    norm_cmd.unsign = 1'b0;
    norm_cmd.round = 1'b0;
    norm_cmd.shift = 5'h00;
    norm_cmd.opa = src1;
    norm_cmd.opb = src2;
    if (is_acc)
    begin
      norm_cmd.sub = funct7[2];
      norm_cmd.unsign = funct7[0];
      norm_cmd.round = funct7[1];
      norm_cmd.shift = src2[4:0];
      norm_cmd.opa = req.dest_old;
      norm_cmd.opb = src1;
    end
    else
    begin
      norm_cmd.sub = funct3 == galu_pkg::F3_NSUB;
      norm_cmd.unsign = f2[0];
      norm_cmd.round = f2[1];
      norm_cmd.shift = shift_imm;
    end
  end

  galu_norm #(
    .WIDTH(WIDTH)
  ) u_norm (
    .cmd(norm_cmd),
    .result(norm_result)
  );

  // ------------------------------------------------------------
  // Result selection.
  // ------------------------------------------------------------
  logic [31:0] next_result;

  always_comb
  begin
    next_result = galu_pkg::RESULT_RST;
    case (op)
      galu_pkg::GALU_ABS:
      begin
        next_result = abs_src1;
      end
      galu_pkg::GALU_SLE:
      begin
        next_result = {31'h0, le_s};
      end
      galu_pkg::GALU_SLEU:
      begin
        next_result = {31'h0, le_u};
      end
      galu_pkg::GALU_MIN:
      begin
        next_result = lt_s ? src1 : src2;
      end
      galu_pkg::GALU_MINU:
      begin
        next_result = lt_u ? src1 : src2;
      end
      galu_pkg::GALU_MAX:
      begin
        next_result = lt_s ? src2 : src1;
      end
      galu_pkg::GALU_MAXU:
      begin
        next_result = lt_u ? src2 : src1;
      end
      galu_pkg::GALU_EXTHS:
      begin
        next_result = ext_hs;
      end
      galu_pkg::GALU_EXTHZ:
      begin
        next_result = ext_hz;
      end
      galu_pkg::GALU_EXTBS:
      begin
        next_result = ext_bs;
      end
      galu_pkg::GALU_EXTBZ:
      begin
        next_result = ext_bz;
      end
      galu_pkg::GALU_CLIP:
      begin
        next_result = clip_s_imm;
      end
      galu_pkg::GALU_CLIPU:
      begin
        next_result = clip_u_imm;
      end
      galu_pkg::GALU_CLIPR:
      begin
        next_result = clip_s_reg;
      end
      galu_pkg::GALU_CLIPUR:
      begin
        next_result = clip_u_reg;
      end
      galu_pkg::GALU_NORM:
      begin
        next_result = norm_result;
      end
      default:
      begin
        next_result = galu_pkg::RESULT_RST;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Response fields.
  // ------------------------------------------------------------
  wire next_valid = req.valid;
  wire next_illegal = req.valid && op == galu_pkg::GALU_ILLEGAL;
  wire [31:0] next_masked = req.valid ? next_result : galu_pkg::RESULT_RST;

  // ------------------------------------------------------------
  // Output register.
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rsp.valid <= 1'b0;
      rsp.illegal <= 1'b0;
      rsp.result <= galu_pkg::RESULT_RST;
    end
    else
    begin
      rsp.valid <= next_valid;
      rsp.illegal <= next_illegal;
      rsp.result <= next_masked;
    end
  end

endmodule

/* File: testbench/galu_top_asserts.sv */
// Concurrent checks of the ALU response against its request.
module galu_top_asserts (
  input wire logic mclk,
  input wire logic srst,
  input wire galu_pkg::galu_req_t req,
  input wire galu_pkg::galu_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Request decode and operands held for the answer cycle.
  // ------------------------------------------------------------
  logic [31:0] q1;
  logic [31:0] q2;
  logic [4:0] qs;
  wire logic [6:0] f7 = req.instr[31:25];
  wire logic rop = req.valid && req.instr[6:0] == galu_pkg::OPC_REG
    && req.instr[14:12] == galu_pkg::F3_REG;
  wire logic nrm = req.valid && req.instr[6:0] == galu_pkg::OPC_NORM
    && req.instr[14:13] == 2'h1;
  always_ff @(posedge mclk)
  begin
    q1 <= req.src1;
    q2 <= req.src2;
    qs <= req.instr[29:25];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_abs;
    rop && f7 == galu_pkg::F7_ABS |=> rsp.result == ($signed(q1) < 0 ? -q1 : q1);
  endproperty
  a_abs: assert property (p_abs)
    else $error("abs result wrong");
  property p_sle;
    rop && f7 == galu_pkg::F7_SLE
      |=> rsp.result == {31'h0, $signed(q1) <= $signed(q2)};
  endproperty
  a_sle: assert property (p_sle)
    else $error("sle result wrong");
  property p_max;
    rop && f7 == galu_pkg::F7_MAX
      |=> rsp.result == ($signed(q1) < $signed(q2) ? q2 : q1);
  endproperty
  a_max: assert property (p_max)
    else $error("max result wrong");
  property p_minu;
    rop && f7 == galu_pkg::F7_MINU |=> rsp.result == (q1 < q2 ? q1 : q2);
  endproperty
  a_minu: assert property (p_minu)
    else $error("minu result wrong");
  property p_ext;
    rop && f7 == galu_pkg::F7_EXTBS |=> rsp.result == {{24{q1[7]}}, q1[7:0]};
  endproperty
  a_ext: assert property (p_ext)
    else $error("byte sign extend wrong");
  property p_clipur;
    rop && f7 == galu_pkg::F7_CLIPUR
      |=> rsp.result == ($signed(q1) <= 0 ? 32'h0 : (q1 >= q2 ? q2 : q1));
  endproperty
  a_clipur: assert property (p_clipur)
    else $error("clipur result wrong");
  property p_normu;
    nrm && req.instr[31:30] == 2'h1 && !req.instr[12]
      |=> rsp.result == (q1 + q2) >> qs;
  endproperty
  a_normu: assert property (p_normu)
    else $error("unsigned normalize wrong");
  property p_ill;
    rop && f7 == 7'h2F |=> rsp.illegal && rsp.result == 32'h0;
  endproperty
  a_ill: assert property (p_ill)
    else $error("undecoded op not flagged");
  property p_nrm;
    nrm |=> rsp.valid && !rsp.illegal;
  endproperty
  a_nrm: assert property (p_nrm)
    else $error("normalize op not taken");
  c_clipr: cover property (rop && f7 == galu_pkg::F7_CLIPR);
  c_nrm: cover property (nrm ##1 rsp.valid);
  c_ill: cover property (rop ##1 rsp.illegal);
endmodule

/* File: testbench/galu_feed.sv */
// Model of the decode and register-file stage feeding the ALU.
module galu_feed (
  input wire logic mclk,
  output galu_pkg::galu_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // ------------------------------------------------------------
  // Presents one request for a cycle, then parks inverted lines.
  // ------------------------------------------------------------
  task automatic send(input logic [31:0] i, a, b, d);
    @(posedge mclk);
    req <= '{1'h1, i, a, b, d};
    @(posedge mclk);
    req <= '{1'h0, ~i, ~a, ~b, ~d};
  endtask
endmodule

/* File: testbench/galu_top_test.sv */
// Self-checking testbench of the general ALU datapath.
module galu_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] z = 32'h0;
  localparam logic [31:0] m1 = 32'hFFFFFFFF;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  galu_pkg::galu_req_t req;
  galu_pkg::galu_rsp_t rsp;
  int miscompares = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  galu_feed feed (.mclk(mclk), .req(req));
  galu_top #(.WIDTH(32)) dut (.mclk(mclk), .srst(srst), .req(req), .rsp(rsp));
  // ------------------------------------------------------------
  // Encoders, compares and the request runner.
  // ------------------------------------------------------------
  function automatic logic [31:0] rf(input logic [6:0] f7);
    return {f7, 10'h0, galu_pkg::F3_REG, 5'h0, galu_pkg::OPC_REG};
  endfunction
  function automatic logic [31:0] cf(input logic [6:0] f7, input logic [4:0] w);
    return rf(f7) | {7'h0, w, 20'h0};
  endfunction
  function automatic logic [31:0] af(input logic [2:0] n);
    return rf({galu_pkg::F7_ACC_HI, n});
  endfunction
  function automatic logic [31:0] nf(input logic [1:0] f2, input logic [4:0] sh,
                                     input logic s);
    return {f2, sh, 10'h0, s ? galu_pkg::F3_NSUB : galu_pkg::F3_NADD, 5'h0,
            galu_pkg::OPC_NORM};
  endfunction
  task automatic chk_w(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_b(input string n, input logic e, g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic go(input string n, input logic [31:0] i, a, b, d, e);
    feed.send(i, a, b, d);
    #1;
    chk_b("valid", 1'h1, rsp.valid);
    chk_b("illegal", 1'h0, rsp.illegal);
    chk_w(n, e, rsp.result);
  endtask
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_cmp;
    go("abs", rf(galu_pkg::F7_ABS), 32'hFFFFFFFB, z, z, 32'h5);
    go("abs", rf(galu_pkg::F7_ABS), 32'h80000000, z, z, 32'h80000000);
    go("sle", rf(galu_pkg::F7_SLE), m1, 32'h1, z, 32'h1);
    go("sle", rf(galu_pkg::F7_SLE), 32'h5, 32'h5, z, 32'h1);
    go("sleu", rf(galu_pkg::F7_SLEU), m1, 32'h1, z, z);
    go("min", rf(galu_pkg::F7_MIN), m1, 32'h1, z, m1);
    go("minu", rf(galu_pkg::F7_MINU), m1, 32'h1, z, 32'h1);
    go("max", rf(galu_pkg::F7_MAX), m1, 32'h1, z, 32'h1);
    go("maxu", rf(galu_pkg::F7_MAXU), m1, 32'h1, z, m1);
  endtask
  task automatic t_ext;
    go("exths", rf(galu_pkg::F7_EXTHS), 32'h12348001, z, z, 32'hFFFF8001);
    go("exthz", rf(galu_pkg::F7_EXTHZ), 32'h12348001, z, z, 32'h8001);
    go("extbs", rf(galu_pkg::F7_EXTBS), 32'h12345680, z, z, 32'hFFFFFF80);
    go("extbz", rf(galu_pkg::F7_EXTBZ), 32'h12345680, z, z, 32'h80);
  endtask
  task automatic t_clip;
    go("clip", cf(galu_pkg::F7_CLIP, 5'h4), 32'h10, z, z, 32'h7);
    go("clip", cf(galu_pkg::F7_CLIP, 5'h4), 32'hFFFFFFF0, z, z, 32'hFFFFFFF8);
    go("clip", cf(galu_pkg::F7_CLIP, 5'h4), 32'h3, z, z, 32'h3);
    go("clip", cf(galu_pkg::F7_CLIP, 5'h0), 32'h5, z, z, z);
    go("clip", cf(galu_pkg::F7_CLIP, 5'h0), 32'hFFFFFFF0, z, z, m1);
    go("clipu", cf(galu_pkg::F7_CLIPU, 5'h4), 32'hFFFFFFF0, z, z, z);
    go("clipu", cf(galu_pkg::F7_CLIPU, 5'h4), 32'h20, z, z, 32'h7);
    go("clipu", cf(galu_pkg::F7_CLIPU, 5'h0), 32'h5, z, z, z);
    go("clipr", rf(galu_pkg::F7_CLIPR), 32'hFFFFF000, 32'hFF, z, 32'hFFFFFF00);
    go("clipr", rf(galu_pkg::F7_CLIPR), 32'h1000, 32'hFF, z, 32'hFF);
    go("clipur", rf(galu_pkg::F7_CLIPUR), m1, 32'hFF, z, z);
    go("clipur", rf(galu_pkg::F7_CLIPUR), 32'h100, 32'hFF, z, 32'hFF);
  endtask
  task automatic t_norm;
    go("addn", nf(2'h0, 5'h4, 1'h0), 32'hFFFFFF00, 32'h10, z, 32'hFFFFFFF1);
    go("subn", nf(2'h0, 5'h4, 1'h1), z, 32'h20, z, 32'hFFFFFFFE);
    go("addun", nf(2'h1, 5'h4, 1'h0), 32'hFFFFFF00, 32'h10, z, 32'h0FFFFFF1);
    go("subun", nf(2'h1, 5'h4, 1'h1), z, 32'h20, z, 32'h0FFFFFFE);
    go("addrn", nf(2'h2, 5'h2, 1'h0), 32'h5, z, z, 32'h1);
    go("addurn", nf(2'h3, 5'h1, 1'h0), m1, z, z, z);
    go("subrn", nf(2'h2, 5'h2, 1'h1), z, 32'h3, z, m1);
    go("suburn", nf(2'h3, 5'h4, 1'h1), z, 32'h8, z, z);
    go("addrn", nf(2'h2, 5'h0, 1'h0), 32'h3, 32'h4, z, 32'h7);
  endtask
  task automatic t_acc;
    go("addnr", af(3'h0), 32'h10, 32'h4, 32'hFFFFFF00, 32'hFFFFFFF1);
    go("subnr", af(3'h4), 32'h20, 32'h24, z, 32'hFFFFFFFE);
    go("addunr", af(3'h1), 32'h10, 32'h4, 32'hFFFFFF00, 32'h0FFFFFF1);
    go("subunr", af(3'h5), 32'h20, 32'h4, z, 32'h0FFFFFFE);
    go("addrnr", af(3'h2), z, 32'h2, 32'h5, 32'h1);
    go("addurnr", af(3'h3), 32'h2, z, 32'h5, 32'h7);
    go("subrnr", af(3'h6), 32'h3, 32'h22, z, m1);
    go("suburnr", af(3'h7), 32'h8, 32'h4, z, z);
  endtask
  task automatic t_bad;
    feed.send(rf(7'h2F), m1, m1, m1);
    #1;
    chk_b("illegal", 1'h1, rsp.illegal);
    chk_w("illegal result", z, rsp.result);
    feed.send(nf(2'h0, 5'h0, 1'h0) ^ 32'h2000, m1, m1, m1);
    #1;
    chk_b("illegal", 1'h1, rsp.illegal);
    fork
      feed.send(rf(galu_pkg::F7_ABS), m1, z, z);
      begin
        @(posedge mclk);
        srst <= 1'h1;
      end
    join
    #1;
    chk_b("valid in reset", 1'h0, rsp.valid);
    chk_w("result in reset", z, rsp.result);
    @(posedge mclk);
    srst <= 1'h0;
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    srst <= 1'h0;
    t_cmp;
    t_ext;
    t_clip;
    t_norm;
    t_acc;
    t_bad;
    t_cmp;
    end_sim;
  end
endmodule
bind galu_top galu_top_asserts chk (.mclk(mclk), .srst(srst), .req(req), .rsp(rsp));
